// ==== verilog/wdt_pkg.sv ====
// Package of constants and types for the windowed watchdog timer
package wdt_pkg;

    // Register addresses on the plain register port
    localparam logic [7:0] WDT_CTRL_ADDR = 8'h3E;
    localparam logic [7:0] WDT_SERVICE_ADDR = 8'h3F;

    // Field positions inside the watchdog_control register
    localparam int WDT_WINDOW_BIT = 7;
    localparam int WDT_DBG_HALT_BIT = 6;
    localparam int WDT_MASK_BIT = 5;
    localparam int WDT_WAIT_BIT = 4;
    localparam int WDT_STOP_BIT = 3;
    localparam int WDT_RATE_MSB = 2;
    localparam int WDT_RATE_LSB = 0;

    // Reset values of the plainly reset control bits
    localparam logic WDT_DBG_HALT_RST = 1'b0;
    localparam logic WDT_WAIT_RST = 1'b0;
    localparam logic WDT_STOP_RST = 1'b0;
    localparam logic [7:0] WDT_READ_ZERO = 8'h00;

    // Rate codes and service values
    localparam logic [2:0] WDT_RATE_OFF = 3'h0;
    localparam logic [2:0] WDT_RATE_MAX = 3'h7;
    localparam logic [7:0] WDT_SVC_FIRST = 8'h55;
    localparam logic [7:0] WDT_SVC_SECOND = 8'hAA;

    // Counter width covers the longest period of 2^16 reference cycles
    localparam int WDT_CNT_W = 17;

    // Service sequence states, one-hot
    typedef enum logic [1:0] {
        WDT_SVC_IDLE = 2'b01,
        WDT_SVC_ARMED = 2'b10
    } wdt_svc_t;

    // Timeout length in reference clock cycles for each rate code
    function automatic logic [WDT_CNT_W-1:0] wdt_period(
        input logic [2:0] rate
    );
        logic [WDT_CNT_W-1:0] p;
        p = 17'h10000;
        case (rate)
            3'h1: p = 17'h00040;
            3'h2: p = 17'h00100;
            3'h3: p = 17'h00400;
            3'h4: p = 17'h01000;
            3'h5: p = 17'h04000;
            3'h6: p = 17'h08000;
            default: p = 17'h10000;
        endcase
        return p;
    endfunction

endpackage

// ==== verilog/wdt_sync.sv ====
// Two-stage synchroniser with rising edge detection
module wdt_sync (
    input wire logic clk_i,    // Block clock
    input wire logic reset_i,  // Synchronous reset, active high
    input wire logic async_i,  // Input from another clock domain
    output logic level_o,      // Synchronised level
    output logic rise_o        // One-cycle pulse on a rising edge
);

    logic meta_r;
    logic sync_r;
    logic last_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Edge found on the settled stages only
    assign level_o = sync_r;
    assign rise_o = sync_r & ~last_r;

endmodule // wdt_sync

// ==== verilog/wdt_core.sv ====
// Windowed watchdog timer with control and service registers
module wdt_core (
    input wire logic clk_i,             // Bus clock, 100 MHz
    input wire logic reset_i,           // Synchronous reset, active high
    input wire logic [7:0] addr_i,      // Register address
    input wire logic [7:0] wdata_i,     // Register write data
    input wire logic wr_i,              // Write strobe
    input wire logic rd_i,              // Read strobe
    output logic [7:0] rdata_o,         // Read data, cycle after rd_i
    input wire logic special_mode_i,    // Special operating mode
    input wire logic debug_mode_i,      // Debug mode active
    input wire logic wait_mode_i,       // Part is in wait mode
    input wire logic stop_mode_i,       // Part is in stop mode
    input wire logic [2:0] nv_rate_i,   // Nonvolatile rate option field
    input wire logic nv_window_i,       // Nonvolatile window option bit
    input wire logic ref_clk_i,         // Internal reference clock pin
    output logic sys_reset_o,           // System reset request, sticky
    output logic pit_halt_o             // Periodic timer halt request
);

    // Control register state
    logic window_r;
    logic dbg_halt_r;
    logic halt_wait_r;
    logic run_stop_r;
    logic [2:0] rate_r;
    logic once_r;

    // Counter and sequence state
    logic [wdt_pkg::WDT_CNT_W-1:0] cnt_r;
    logic restart_pend_r;
    wdt_pkg::wdt_svc_t svc_r;
    wdt_pkg::wdt_svc_t svc_nxt;
    logic sys_reset_r;
    logic pit_halt_r;
    logic [7:0] rdata_r;

    // Decoded accesses and derived conditions
    logic ref_rise;
    logic wr_ctrl;
    logic wr_svc;
    logic rd_ctrl;
    logic masked;
    logic cfg_ok;
    logic [2:0] wr_rate;
    logic rate_restart;
    logic dbg_restart;
    logic enabled;
    logic dbg_force;
    logic [2:0] eff_rate;
    logic eff_window;
    logic [wdt_pkg::WDT_CNT_W-1:0] period;
    logic [wdt_pkg::WDT_CNT_W-1:0] last_cnt;
    logic [wdt_pkg::WDT_CNT_W-1:0] open_at;
    logic frozen;
    logic wait_init;
    logic at_end;
    logic timeout;
    logic early;
    logic val_first;
    logic val_second;
    logic bad_svc;
    logic svc_restart;
    logic restart_evt;

    // Reference clock brought into the bus clock domain
    wdt_sync u_ref_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(ref_clk_i),
        .level_o(),
        .rise_o(ref_rise)
    );

    // Register address decode
    assign wr_ctrl = wr_i & (addr_i == wdt_pkg::WDT_CTRL_ADDR);
    assign wr_svc = wr_i & (addr_i == wdt_pkg::WDT_SERVICE_ADDR);
    assign rd_ctrl = rd_i & (addr_i == wdt_pkg::WDT_CTRL_ADDR);

    // Configuration write qualification
    assign masked = wdata_i[wdt_pkg::WDT_MASK_BIT];
    assign cfg_ok = wr_ctrl & ~masked
                    & (special_mode_i | ~once_r);
    assign wr_rate = wdata_i[wdt_pkg::WDT_RATE_MSB:wdt_pkg::WDT_RATE_LSB];

    // Restart causes from the control register
    assign rate_restart = cfg_ok
                          & (wr_rate != wdt_pkg::WDT_RATE_OFF);
    assign dbg_restart = wr_ctrl & wdata_i[wdt_pkg::WDT_DBG_HALT_BIT]
                         & ~dbg_halt_r;

    // Effective rate and window, forced while debugging in special mode
    assign enabled = (rate_r != wdt_pkg::WDT_RATE_OFF);
    assign dbg_force = enabled & debug_mode_i & ~dbg_halt_r
                       & special_mode_i;
    assign eff_rate = dbg_force ? wdt_pkg::WDT_RATE_MAX : rate_r;
    assign eff_window = window_r & ~dbg_force;

    // Period and the start of the open window
    assign period = wdt_pkg::wdt_period(eff_rate);
    assign last_cnt = period - 17'h00001;
    assign open_at = period - (period >> 2);

    // Low-power and debug freezing
    assign frozen = (debug_mode_i & dbg_halt_r)
                    | (stop_mode_i & ~run_stop_r)
                    | (wait_mode_i & halt_wait_r);
    assign wait_init = wait_mode_i & halt_wait_r;

    // Timeout on the last reference cycle of the period
    assign at_end = (cnt_r >= last_cnt);
    assign timeout = enabled & ref_rise & ~restart_pend_r & ~frozen
                     & ~wait_init & at_end;

    // Service write classification
    assign val_first = (wdata_i == wdt_pkg::WDT_SVC_FIRST);
    assign val_second = (wdata_i == wdt_pkg::WDT_SVC_SECOND);
    assign early = eff_window
                   & (restart_pend_r | (cnt_r < open_at));
    assign bad_svc = wr_svc & enabled
                     & (early
                        | (~val_first & ~val_second)
                        | (eff_window & val_second
                           & (svc_r != wdt_pkg::WDT_SVC_ARMED)));
    assign svc_restart = wr_svc & enabled & ~bad_svc & val_second
                         & (svc_r == wdt_pkg::WDT_SVC_ARMED);

    // All restart causes gathered for the crossing
    assign restart_evt = rate_restart | dbg_restart | svc_restart;

    // Debug-halt select bit
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dbg_halt_r <= wdt_pkg::WDT_DBG_HALT_RST;
        end else if (wr_ctrl) begin
            if (special_mode_i) begin
                dbg_halt_r <= wdata_i[wdt_pkg::WDT_DBG_HALT_BIT];
            end else if (wdata_i[wdt_pkg::WDT_DBG_HALT_BIT]) begin
                dbg_halt_r <= 1'b1;
            end
        end
    end

    // Rate field, loaded inverted from the option field at reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rate_r <= ~nv_rate_i;
        end else if (cfg_ok) begin
            if (special_mode_i | (wr_rate != wdt_pkg::WDT_RATE_OFF)) begin
                rate_r <= wr_rate;
            end
        end
    end

    // Window select, loaded inverted from the option bit at reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            window_r <= ~nv_window_i;
        end else if (cfg_ok) begin
            if (special_mode_i | wdata_i[wdt_pkg::WDT_WINDOW_BIT]) begin
                window_r <= wdata_i[wdt_pkg::WDT_WINDOW_BIT];
            end
        end
    end

    // Wait-halt and stop-run selections
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            halt_wait_r <= wdt_pkg::WDT_WAIT_RST;
            run_stop_r <= wdt_pkg::WDT_STOP_RST;
        end else if (cfg_ok) begin
            halt_wait_r <= wdata_i[wdt_pkg::WDT_WAIT_BIT];
            run_stop_r <= wdata_i[wdt_pkg::WDT_STOP_BIT];
        end
    end

    // Single-write tracking; a masked write does not use it up
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            once_r <= 1'b0;
        end else if (wr_ctrl & ~masked) begin
            once_r <= 1'b1;
        end
    end

    // Restart request held until the next reference edge takes it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            restart_pend_r <= 1'b0;
        end else begin
            restart_pend_r <= restart_evt
                              | (restart_pend_r & ~ref_rise);
        end
    end

    // Watchdog counter, advanced once per reference clock cycle
    always_ff @(posedge clk_i) begin
        if (reset_i | ~enabled) begin
            cnt_r <= '0;
        end else if (wait_init) begin
            cnt_r <= '0;
        end else if (ref_rise) begin
            if (restart_pend_r) begin
                cnt_r <= '0;
            end else if (frozen) begin
                cnt_r <= cnt_r;
            end else if (at_end) begin
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 17'h00001;
            end
        end
    end

    // Service sequence next state
    always_comb begin
        svc_nxt = svc_r;
        if (~enabled) begin
            svc_nxt = wdt_pkg::WDT_SVC_IDLE;
        end else if (wr_svc & ~bad_svc) begin
            case (svc_r)
                wdt_pkg::WDT_SVC_IDLE: begin
                    if (val_first) begin
                        svc_nxt = wdt_pkg::WDT_SVC_ARMED;
                    end
                end
                wdt_pkg::WDT_SVC_ARMED: begin
                    if (val_second) begin
                        svc_nxt = wdt_pkg::WDT_SVC_IDLE;
                    end
                end
                default: begin
                    svc_nxt = wdt_pkg::WDT_SVC_IDLE;
                end
            endcase
        end
    end

    // Service sequence state
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            svc_r <= wdt_pkg::WDT_SVC_IDLE;
        end else begin
            svc_r <= svc_nxt;
        end
    end

    // System reset request, held until the system resets the block
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sys_reset_r <= 1'b0;
        end else if (timeout | bad_svc) begin
            sys_reset_r <= 1'b1;
        end
    end

    // Periodic timer halt follows debug mode when debug-halt is set
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pit_halt_r <= 1'b0;
        end else begin
            pit_halt_r <= debug_mode_i & dbg_halt_r;
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_r <= wdt_pkg::WDT_READ_ZERO;
        end else if (rd_ctrl) begin
            rdata_r <= {window_r, dbg_halt_r, 1'b0, halt_wait_r,
                        run_stop_r, rate_r};
        end else begin
            rdata_r <= wdt_pkg::WDT_READ_ZERO;
        end
    end

    // Outputs straight from flip-flops
    assign rdata_o = rdata_r;
    assign sys_reset_o = sys_reset_r;
    assign pit_halt_o = pit_halt_r;

endmodule // wdt_core

// ==== testbench/wdt_core_props.sv ====
// Concurrent checks on the watchdog core ports
module wdt_props (
    input wire logic clk_i,          // Bus clock
    input wire logic reset_i,        // Synchronous reset
    input wire logic [7:0] addr_i,   // Register address
    input wire logic wr_i,           // Write strobe
    input wire logic rd_i,           // Read strobe
    input wire logic [7:0] rdata_o,  // Read data
    input wire logic debug_mode_i,   // Debug mode
    input wire logic ref_clk_i,      // Reference clock
    input wire logic sys_reset_o,    // Reset request
    input wire logic pit_halt_o      // Timer halt
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [3:0] ref_age_r;

    // Cycles since the reference clock was last seen high
    always_ff @(posedge clk_i) begin
        if (ref_clk_i) begin
            ref_age_r <= 4'h0;
        end else if (ref_age_r != 4'hF) begin
            ref_age_r <= ref_age_r + 4'h1;
        end
    end

    // Reads of each register
    sequence s_ctrl_rd;
        rd_i && addr_i == wdt_pkg::WDT_CTRL_ADDR;
    endsequence
    sequence s_svc_rd;
        rd_i && addr_i == wdt_pkg::WDT_SERVICE_ADDR;
    endsequence

    a_idle_read_zero: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("Read data not zero outside a read");
    a_svc_read_zero: assert property (s_svc_rd |=> rdata_o == 8'h00)
        else $error("Service register read not zero");
    a_unmapped_zero: assert property (rd_i && addr_i < 8'h3E
        |=> rdata_o == 8'h00) else $error("Unmapped read not zero");
    a_mask_reads_zero: assert property (s_ctrl_rd |=> !rdata_o[5])
        else $error("Write mask bit read back");
    a_ctrl_read_stable: assert property (s_ctrl_rd ##1 s_ctrl_rd
        |=> $stable(rdata_o)) else $error("Control changed without write");
    a_reset_sticky: assert property (sys_reset_o |=> sys_reset_o)
        else $error("Reset request dropped");
    a_halt_needs_debug: assert property (pit_halt_o
        |-> $past(debug_mode_i)) else $error("Timer halt outside debug mode");
    a_reset_has_cause: assert property ($rose(sys_reset_o)
        |-> $past(wr_i) || ref_age_r < 4'h6)
        else $error("Reset request without write or reference edge");
endmodule // wdt_props

bind wdt_core wdt_props u_props (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .debug_mode_i(debug_mode_i), .ref_clk_i(ref_clk_i),
    .sys_reset_o(sys_reset_o), .pit_halt_o(pit_halt_o));

// ==== testbench/tb_windowed_watchdog_timer.sv ====
// Self-checking testbench of the windowed watchdog core
module tb_windowed_watchdog_timer;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic wr; logic [7:0] a; logic [7:0] d;} wdt_row_t;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic special_mode_i = 1'b0;
    logic debug_mode_i = 1'b0;
    logic wait_mode_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic [2:0] nv_rate_i = 3'h6;
    logic nv_window_i = 1'b1;
    logic ref_clk_i = 1'b0;
    logic [7:0] rdata_o;
    logic sys_reset_o;
    logic pit_halt_o;
    int err_count = 0;
    int n_tests = 0;
    // Reads carry the expected value in d; writes carry the data
    wdt_row_t rows [12] = '{'{1'b0, 8'h3E, 8'h01}, '{1'b0, 8'h3F, 8'h00},
        '{1'b1, 8'h3F, 8'h55}, '{1'b1, 8'h3F, 8'hAA},
        '{1'b1, 8'h40, 8'hFF}, '{1'b0, 8'h40, 8'h00},
        '{1'b1, 8'h3E, 8'h60}, '{1'b0, 8'h3E, 8'h41},
        '{1'b1, 8'h3E, 8'h00}, '{1'b0, 8'h3E, 8'h41},
        '{1'b1, 8'h3E, 8'h9F}, '{1'b0, 8'h3E, 8'h41}};

    wdt_core dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .special_mode_i(special_mode_i), .debug_mode_i(debug_mode_i),
        .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i),
        .nv_rate_i(nv_rate_i), .nv_window_i(nv_window_i),
        .ref_clk_i(ref_clk_i), .sys_reset_o(sys_reset_o),
        .pit_halt_o(pit_halt_o));

    // Bus clock and an unrelated reference clock of about 8 bus cycles
    always #5 clk_i = ~clk_i;
    always #40.3 ref_clk_i = ~ref_clk_i;

    task automatic end_of_test();
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", exp, rdata_o);
    endtask

    // Reset request one cycle after the last write
    task automatic chk_rst(logic exp);
        @(posedge clk_i);
        #1;
        chk("sys_reset", 8'(exp), 8'(sys_reset_o));
    endtask

    task automatic ref_wait(int n);
        repeat (n) @(posedge ref_clk_i);
        @(posedge clk_i);
    endtask

    // Watchdog against a hang
    initial begin
        #200us;
        err_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        do_reset();
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd_chk(rows[i].a, rows[i].d);
            end
        end
        // Counter frozen while debug mode lasts
        @(posedge clk_i);
        debug_mode_i <= 1'b1;
        ref_wait(100);
        chk("pit_halt", 8'h01, 8'(pit_halt_o));
        @(posedge clk_i);
        debug_mode_i <= 1'b0;
        ref_wait(50);
        chk_rst(1'b0);
        // Timeout of 64 reference cycles
        wr(8'h3F, 8'h55);
        wr(8'h3F, 8'hAA);
        ref_wait(61);
        chk_rst(1'b0);
        ref_wait(5);
        chk_rst(1'b1);
        // Special mode: fields writable anytime, debug bit clearable
        special_mode_i <= 1'b1;
        do_reset();
        wr(8'h3E, 8'h82);
        wr(8'h3E, 8'h60);
        wr(8'h3E, 8'h20);
        wr(8'h3E, 8'h81);
        rd_chk(8'h3E, 8'h81);
        ref_wait(10);
        wr(8'h3F, 8'h55);
        chk_rst(1'b1);
        do_reset();
        wr(8'h3E, 8'h81);
        ref_wait(56);
        wr(8'h3F, 8'h55);
        wr(8'h3F, 8'h55);
        wr(8'h3F, 8'hAA);
        chk_rst(1'b0);
        wr(8'h3F, 8'h55);
        chk_rst(1'b1);
        // Disabled watchdog ignores service writes and never times out
        special_mode_i <= 1'b0;
        nv_rate_i <= 3'h7;
        do_reset();
        wr(8'h3F, 8'h12);
        ref_wait(70);
        chk_rst(1'b0);
        nv_rate_i <= 3'h6;
        do_reset();
        wr(8'h3F, 8'h12);
        chk_rst(1'b1);
        // Wait mode with halt_in_wait reinitialises the counter
        do_reset();
        wr(8'h3E, 8'h11);
        ref_wait(40);
        wait_mode_i <= 1'b1;
        ref_wait(100);
        wait_mode_i <= 1'b0;
        ref_wait(40);
        chk_rst(1'b0);
        // Back-to-back control reads, then stop mode with and without run
        do_reset();
        @(posedge clk_i);
        addr_i <= 8'h3E;
        rd_i <= 1'b1;
        @(posedge clk_i);
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata", 8'h01, rdata_o);
        @(posedge clk_i);
        stop_mode_i <= 1'b1;
        ref_wait(100);
        stop_mode_i <= 1'b0;
        ref_wait(20);
        chk_rst(1'b0);
        wr(8'h3E, 8'h09);
        stop_mode_i <= 1'b1;
        ref_wait(70);
        chk_rst(1'b1);
        // Debugging in special mode forces the longest unwindowed period
        do_reset();
        special_mode_i <= 1'b1;
        stop_mode_i <= 1'b0;
        debug_mode_i <= 1'b1;
        ref_wait(70);
        chk_rst(1'b0);
        chk("pit_halt", 8'h00, 8'(pit_halt_o));
        @(posedge clk_i);
        debug_mode_i <= 1'b0;
        ref_wait(2);
        chk_rst(1'b1);
        end_of_test();
    end
endmodule // tb_windowed_watchdog_timer
